//--- shared/cim_regs.vh
// Constants for the cache init-mode control block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 32-bit AHB-Lite register bus and a 200 MHz core clock.
`ifndef CIM_REGS_VH
`define CIM_REGS_VH

// Register byte offsets
`define CIM_OFF_MANY      8'h00
`define CIM_OFF_ONCE      8'h04
`define CIM_OFF_STATUS    8'h08
`define CIM_OFF_ROMCTL    8'h0c

// Rewritable chain field positions
`define CIM_L2ON_BIT      0
`define CIM_DUP_HI        14
`define CIM_DUP_LO        12
`define CIM_SIZE_HI       4
`define CIM_SIZE_LO       1
`define CIM_I2M_HI        6
`define CIM_I2M_LO        5
`define CIM_SDE_HI        9
`define CIM_SDE_LO        7
`define CIM_INIT_BIT      10
`define CIM_EVICT_BIT     11
`define CIM_WSTS_HI       18
`define CIM_WSTS_LO       15
`define CIM_BANK_BIT      19
`define CIM_MANY_W        20

// Reset values: second-level cache off
`define CIM_MANY_RESET    20'h00000
`define CIM_ONCE_RESET    32'h00000000

// Boot chain length and serial clocking
`define CIM_ONCE_W        32
`define CIM_LAST_BIT      6'h1f
`define CIM_ROM_DIV       8'h04

`endif

//--- rtl/cim_shift_chain.v
// Serial-in shift chain used for the boot-loaded configuration chain.
// Assumes serial data already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none

module cim_shift_chain #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst,
    // Serial load
    input  wire             shiftEn,
    input  wire             serialIn,
    // Parallel view
    output reg [WIDTH-1:0]  chainQ
);

    // Shift in LSB first, so the first bit ends at the bottom after WIDTH shifts
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            chainQ <= {WIDTH{1'b0}};
        end else if (shiftEn) begin
            chainQ <= {serialIn, chainQ[WIDTH-1:1]};
        end
    end

endmodule

`default_nettype wire

//--- rtl/cim_cache_init_ctrl.v
// Cache controller configuration with an initialization mode: boot-loaded
// chain from a serial ROM, rewritable chain over AHB-Lite, and the gating
// of dirty state, second-level write status and victim write-backs.
// Assumes a single 200 MHz clock; ROM data pin is asynchronous.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cim_regs.vh"

module cim_cache_init_ctrl (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Serial boot ROM
    input  wire        romData,
    output reg         romClk,
    output reg         romOutEn_n,
    // Cache datapath requests
    input  wire        dcFillReq,
    input  wire        dcFillDirty,
    input  wire        l2UpdReq,
    input  wire [3:0]  l2UpdStsNormal,
    input  wire        victimReq,
    // Controls to the cache datapath
    output reg         dcFillValid,
    output reg         dcFillDirtyOut,
    output reg         l2UpdValid,
    output reg  [3:0]  l2UpdSts,
    output reg         victimCmdValid,
    output reg         internalBlockOk,
    output reg         l2CacheOn,
    output reg  [3:0]  l2SizeField,
    output reg         bootDone
);

    // ------------------------------------------------------------
    // Serial ROM load of the boot-loaded chain
    // ------------------------------------------------------------
    reg        romSync1_q;
    reg        romSync2_q;
    reg [7:0]  divCnt_q;
    reg [5:0]  bitCnt_q;
    reg        loading_q;
    wire       sampleTick;
    wire [31:0] bootChain;

    // Two flops before anyone reads the pin
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            romSync1_q <= 1'b0;
            romSync2_q <= 1'b0;
        end else begin
            romSync1_q <= romData;
            romSync2_q <= romSync1_q;
        end
    end

    // Divider makes the ROM clock; sample at the end of its low half, on the edge where it rises
    assign sampleTick = loading_q && (divCnt_q == `CIM_ROM_DIV - 8'h01) && !romClk;

    // Load sequencer starts at reset release, runs once
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_q   <= 8'h00;
            bitCnt_q   <= 6'h00;
            loading_q  <= 1'b1;
            romClk     <= 1'b0;
            romOutEn_n <= 1'b1;
            bootDone   <= 1'b0;
        end else if (loading_q) begin
            romOutEn_n <= 1'b0;
            if (divCnt_q == `CIM_ROM_DIV - 8'h01) begin
                divCnt_q <= 8'h00;
                romClk   <= ~romClk;
                if (!romClk) begin
                    // Last bit ends the load; only a new reset starts another
                    if (bitCnt_q == `CIM_LAST_BIT) begin
                        loading_q <= 1'b0;
                        bootDone  <= 1'b1;
                    end
                    bitCnt_q <= bitCnt_q + 6'h01;
                end
            end else begin
                divCnt_q <= divCnt_q + 8'h01;
            end
        end else begin
            romClk     <= 1'b0;
            romOutEn_n <= 1'b1;
        end
    end

    // Shift chain holding the boot_loaded_config_chain settings
    cim_shift_chain #(
        .WIDTH    (`CIM_ONCE_W)
    ) uBootChain (
        .clk      (ref_clk),
        .rst      (sys_rst),
        .shiftEn  (sampleTick),
        .serialIn (romSync2_q),
        .chainQ   (bootChain)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave and rewritable chain
    // ------------------------------------------------------------
    reg [19:0] many_q;
    reg        wrPend_q;
    reg [7:0]  addr_q;
    wire       addrPhase;
    wire       initMode;
    wire [1:0] invToMod;

    // Only whole words are expected, so hsize is not decoded
    // Taken only when the bus is ready; busy and idle are skipped
    assign addrPhase = hsel && hready && htrans[1];

    // Mode decode read by the status register and the gating below
    assign initMode = many_q[`CIM_INIT_BIT];
    assign invToMod = many_q[`CIM_I2M_HI:`CIM_I2M_LO];

    // Address phase capture; zero wait states so hreadyout stays high
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wrPend_q  <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_q  <= addrPhase && hwrite;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addrPhase) begin
                addr_q <= haddr;
            end
        end
    end

    // Reset turns the l2 off; each write to the MANY offset replaces the chain
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            many_q <= `CIM_MANY_RESET;
        end else if (wrPend_q && addr_q == `CIM_OFF_MANY) begin
            many_q <= hwdata[`CIM_MANY_W-1:0];
        end
    end

    // Read data registered in the address phase so it stands in the data phase
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            case (haddr)
                `CIM_OFF_MANY:   hrdata <= {12'h000, many_q};
                `CIM_OFF_ONCE:   hrdata <= bootDone ? bootChain : 32'h00000000;
                `CIM_OFF_STATUS: hrdata <= {29'h00000000, internalBlockOk, initMode, bootDone};
                `CIM_OFF_ROMCTL: hrdata <= {26'h0000000, bitCnt_q};
                default:         hrdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Initialization-mode gating
    // ------------------------------------------------------------
    // Duplicate enable bits are stored only; keeping them zero in init
    // mode is left to firmware, hardware does not police them.
    // Every control is registered, so requests see one cycle of latency
    // and no combinational path reaches the datapath.

    // Registered datapath controls; init mode off falls back to normal
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dcFillValid     <= 1'b0;
            dcFillDirtyOut  <= 1'b0;
            l2UpdValid      <= 1'b0;
            l2UpdSts        <= 4'h0;
            victimCmdValid  <= 1'b0;
            internalBlockOk <= 1'b0;
            l2CacheOn       <= 1'b0;
            l2SizeField     <= 4'h0;
        end else begin
            dcFillValid     <= dcFillReq;
            dcFillDirtyOut  <= dcFillDirty && !initMode;
            l2UpdValid      <= l2UpdReq;
            l2UpdSts        <= initMode ? many_q[`CIM_WSTS_HI:`CIM_WSTS_LO]
                                        : l2UpdStsNormal;
            victimCmdValid  <= victimReq && !initMode;
            internalBlockOk <= initMode && (invToMod != 2'b00);
            l2CacheOn       <= many_q[`CIM_L2ON_BIT];
            l2SizeField     <= many_q[`CIM_SIZE_HI:`CIM_SIZE_LO];
        end
    end

endmodule

`default_nettype wire

//--- tb/cim_rom_model.sv
// Serial boot ROM model: one word, LSB first, next bit after each romClk rise.
// Assumes romClk only toggles while romOutEn_n is low.
`timescale 1ns/1ps
`default_nettype none
module cim_rom_model #(
    parameter logic [31:0] WORD = 32'h0
) (
    // Link from the block
    input  wire logic romClk,
    input  wire logic romOutEn_n,
    // Serial data back
    output logic      romData
);
    logic [4:0] bitIdx_q;
    // Restart on deselect so a second reset reloads from bit 0
    always @(posedge romClk or posedge romOutEn_n) begin
        if (romOutEn_n)
            bitIdx_q <= 5'h0;
        else
            bitIdx_q <= bitIdx_q + 5'h1;
    end
    // Released pin shows the inverse of the last bit, not a stale copy
    assign romData = romOutEn_n ? ~WORD[31] : WORD[bitIdx_q];
endmodule
`default_nettype wire

//--- tb/cim_cache_init_ctrl_sva.sv
// Port checker for the cache init-mode control block.
// Assumes a bind onto cim_cache_init_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cim_ctrl_sva (
    // Clock, reset, bus answer
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // Boot ROM link
    input wire logic       romClk,
    input wire logic       romOutEn_n,
    input wire logic       bootDone,
    // Datapath
    input wire logic       l2UpdReq,
    input wire logic       l2UpdValid,
    input wire logic       victimReq,
    input wire logic       victimCmdValid,
    input wire logic       dcFillDirtyOut,
    input wire logic       internalBlockOk,
    input wire logic       l2CacheOn,
    input wire logic [3:0] l2SizeField
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Gating pairs: init mode with nonzero inv-to-mod shows as internalBlockOk one cycle later, the same cycle as the gated outputs
    a_init_clean: assert property (!(internalBlockOk && dcFillDirtyOut)) else $error("dirty fill in init");
    a_init_victim: assert property (!(internalBlockOk && victimCmdValid)) else $error("victim in init");
    a_victim_cause: assert property (victimCmdValid |-> $past(victimReq)) else $error("victim uncaused");
    a_upd_follow: assert property (l2UpdValid == $past(l2UpdReq) || $past(sys_rst)) else $error("upd valid");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer");
    a_off_reset: assert property ($fell(sys_rst) |-> !l2CacheOn && l2SizeField == 4'h0) else $error("l2 on");
    a_boot_hold: assert property ($past(bootDone) |-> bootDone && romOutEn_n) else $error("boot hold");
    a_rom_idle: assert property (romOutEn_n && $past(romOutEn_n) |-> !romClk) else $error("rom clk idle");
    c_boot: cover property ($rose(bootDone));
    c_init: cover property (internalBlockOk);
    c_victim: cover property (victimCmdValid);
endmodule
bind cim_cache_init_ctrl cim_ctrl_sva u_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .hreadyout(hreadyout),
    .hresp(hresp), .romClk(romClk), .romOutEn_n(romOutEn_n), .bootDone(bootDone), .l2UpdReq(l2UpdReq),
    .l2UpdValid(l2UpdValid), .victimReq(victimReq), .victimCmdValid(victimCmdValid),
    .dcFillDirtyOut(dcFillDirtyOut), .internalBlockOk(internalBlockOk), .l2CacheOn(l2CacheOn),
    .l2SizeField(l2SizeField));
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench: AHB-Lite master, boot ROM model, datapath stimulus.
// Assumes the block answers with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] ROM_WORD = 32'hc3a5_9617; // Arbitrary pattern
    logic        ref_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, rd;
    logic        dcFillReq = 1'b0, dcFillDirty = 1'b0, l2UpdReq = 1'b0, victimReq = 1'b0;
    logic [3:0]  l2UpdStsNormal = 4'h0;
    wire  [31:0] hrdata;
    wire  [3:0]  l2UpdSts, l2SizeField;
    wire         hreadyout, hresp, romData, romClk, romOutEn_n, dcFillValid, dcFillDirtyOut;
    wire         l2UpdValid, victimCmdValid, internalBlockOk, l2CacheOn, bootDone;
    int          failures = 0, comparisons = 0, cycles = 0;
    cim_cache_init_ctrl u_dut (.ref_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .romData, .romClk, .romOutEn_n, .dcFillReq,
        .dcFillDirty, .l2UpdReq, .l2UpdStsNormal, .victimReq, .dcFillValid, .dcFillDirtyOut, .l2UpdValid,
        .l2UpdSts, .victimCmdValid, .internalBlockOk, .l2CacheOn, .l2SizeField, .bootDone);
    cim_rom_model #(.WORD(ROM_WORD)) u_rom (.romClk, .romOutEn_n, .romData);
    initial forever #2.5 ref_clk = ~ref_clk;
    // Hang guard: boot takes a few hundred cycles, all tests well under 5000
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Outputs checked two edges after the mode write, with the datapath requests held
    task automatic dp(input logic dirty, input logic [3:0] sts, input logic vic, input logic ok);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("fill valid", 32'h1, {31'h0, dcFillValid});
        chk("fill dirty", {31'h0, dirty}, {31'h0, dcFillDirtyOut});
        chk("l2 status", {28'h0, sts}, {28'h0, l2UpdSts});
        chk("victim cmd", {31'h0, vic}, {31'h0, victimCmdValid});
        chk("internal ok", {31'h0, ok}, {31'h0, internalBlockOk});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_reset();
        bus(1'b0, 8'h00, 32'h0);
        chk("many reset", 32'h0, rd);
        chk("l2 on reset", 32'h0, {31'h0, l2CacheOn});
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    task automatic s_boot();
        for (int i = 0; i < 1000 && bootDone !== 1'b1; i++) @(posedge ref_clk);
        chk("boot done", 32'h1, {31'h0, bootDone});
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b0, 8'h04, 32'h0);
        chk("boot chain", ROM_WORD, rd);
    endtask
    task automatic s_rewrite();
        bus(1'b1, 8'h00, 32'h7); // L2 on, size 3
        bus(1'b0, 8'h00, 32'h0);
        chk("many read", 32'h7, rd);
        chk("l2 size", 32'h13, {27'h0, l2CacheOn, l2SizeField});
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b0, 8'h00, 32'h0);
        chk("l2 off", 32'h0, {27'h0, l2CacheOn, l2SizeField});
    endtask
    task automatic s_init();
        dcFillReq <= 1'b1;
        dcFillDirty <= 1'b1;
        l2UpdReq <= 1'b1;
        victimReq <= 1'b1;
        l2UpdStsNormal <= 4'h3;
        bus(1'b1, 8'h00, 32'h0043f); // On, size f, inv-to-mod 1, init, status 0
        dp(1'b0, 4'h0, 1'b0, 1'b1);
        bus(1'b0, 8'h08, 32'h0);
        chk("status", 32'h7, rd);
    endtask
    task automatic s_normal();
        bus(1'b1, 8'h00, 32'h1); // L2 kept on, init mode cleared after its init pass
        dp(1'b1, 4'h3, 1'b1, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        s_reset();
        s_boot();
        s_init();
        s_normal();
        s_rewrite();
        results();
    end
endmodule
`default_nettype wire
